//--- logic/isr_core.sv
/*
  Service request, serial/parallel poll and remote/local control of a
  multi-output supply on an instrument bus.
  Assumes the bus transceiver decodes addressing and bus messages into
  levels arriving asynchronously; fault and command inputs are on clock_i.
*/
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps

module isr_core
(
  input wire logic clock_i,
  input wire logic srst_i,
  // Register port
  input wire logic [isr_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [isr_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [isr_pkg::DATA_W-1:0] reg_rdata_o,
  // Bus pins and decoded transceiver levels (asynchronous)
  input wire logic ren_i,
  input wire logic atn_i,
  input wire logic eoi_i,
  input wire logic listen_addr_i,
  input wire logic talk_addr_i,
  input wire logic spoll_active_i,
  input wire logic dev_clear_i,
  input wire logic go_to_local_i,
  input wire logic lockout_i,
  input wire logic srq_n_i,
  output logic srq_n_o,
  output logic srq_n_oe_o,
  output logic [7:0] dio_o,
  output logic [7:0] dio_oe_o,
  // Supply side (same clock)
  input wire logic [isr_pkg::NUM_OUT-1:0] fault_i,
  input wire logic prog_err_i,
  input wire logic clear_supply_command_i,
  input wire logic cmd_busy_i,
  input wire logic return_to_local_key_i,
  // Front panel
  output logic panel_prog_en_o,
  output logic srq_led_o,
  output logic addr_led_o,
  output logic remote_led_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  isr_pkg::isr_pins_t pin_raw; // Raw pin bundle
  isr_pkg::isr_pins_t sync1_q; // First stage, read only by second
  isr_pkg::isr_pins_t sync2_q; // Safe levels
  isr_pkg::isr_pins_t prev_q; // Delayed copy for edge detection

  assign pin_raw = '{ren: ren_i, atn: atn_i, eoi: eoi_i,
                     lstn: listen_addr_i, tlkr: talk_addr_i,
                     spas: spoll_active_i, dcl: dev_clear_i,
                     gtl: go_to_local_i, llo: lockout_i,
                     srq_n: srq_n_i};

  // Two flops per pin plus one for edges
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  logic spoll_end; // Serial poll just finished
  logic dcl_rise; // Device Clear message arrived
  logic gtl_rise; // Go-to-local message arrived
  logic ppoll; // Parallel poll identify on the bus

  assign spoll_end = prev_q.spas & ~sync2_q.spas;
  assign dcl_rise = sync2_q.dcl & ~prev_q.dcl;
  assign gtl_rise = sync2_q.gtl & ~prev_q.gtl;
  assign ppoll = sync2_q.atn & sync2_q.eoi;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [5:0] ctrl_q, ctrl_d; // Enables: power-on, faults, prog error
  logic [4:0] busaddr_q, busaddr_d; // Bus address 0 to 30
  logic [7:0] ppcfg_q, ppcfg_d; // Remote parallel poll setup
  logic aerr_q, aerr_d; // Address range error, sticky
  logic [isr_pkg::DATA_W-1:0] rdata_q, rdata_d; // Read data
  logic [7:0] sbyte; // Serial poll status byte
  logic rqs; // Request pending
  isr_pkg::isr_rl_t rl_q, rl_d; // Remote/local state

  logic wr_ctrl, wr_addr, wr_pp, rd_status;
  assign wr_ctrl = reg_wr_i & (reg_addr_i == isr_pkg::OFS_CTRL);
  assign wr_addr = reg_wr_i & (reg_addr_i == isr_pkg::OFS_BUSADDR);
  assign wr_pp = reg_wr_i & (reg_addr_i == isr_pkg::OFS_PPCFG);
  assign rd_status = reg_rd_i & (reg_addr_i == isr_pkg::OFS_STATUS);

  // Next register values and read mux
  always_comb
  begin
    ctrl_d = ctrl_q;
    busaddr_d = busaddr_q;
    ppcfg_d = ppcfg_q;
    aerr_d = aerr_q;
    rdata_d = '0;
    if (wr_ctrl)
    begin
      ctrl_d = reg_wdata_i[5:0];
    end
    if (wr_pp)
    begin
      ppcfg_d = reg_wdata_i[7:0];
    end
    // Reading status clears the range error
    if (rd_status)
    begin
      aerr_d = 1'b0;
    end
    if (wr_addr)
    begin
      if (reg_wdata_i[15:5] != '0 ||
          reg_wdata_i[4:0] > isr_pkg::BUSADDR_MAX)
      begin
        aerr_d = 1'b1; // Set wins over the read clear
      end
      else
      begin
        busaddr_d = reg_wdata_i[4:0];
      end
    end
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        isr_pkg::OFS_CTRL: rdata_d = {10'h000, ctrl_q};
        isr_pkg::OFS_BUSADDR: rdata_d = {11'h000, busaddr_q};
        isr_pkg::OFS_PPCFG: rdata_d = {8'h00, ppcfg_q};
        isr_pkg::OFS_STATUS:
        begin
          rdata_d[isr_pkg::ST_RQS_BIT] = rqs;
          rdata_d[isr_pkg::ST_REM_BIT] = (rl_q == isr_pkg::ISR_REMOTE) |
                                        (rl_q == isr_pkg::ISR_REMOTE_LOCK);
          rdata_d[isr_pkg::ST_LOCK_BIT] =
            (rl_q == isr_pkg::ISR_REMOTE_LOCK) |
            (rl_q == isr_pkg::ISR_LOCAL_LOCK);
          rdata_d[isr_pkg::ST_AERR_BIT] = aerr_q;
          rdata_d[isr_pkg::ST_SRQLINE_BIT] = ~sync2_q.srq_n;
          rdata_d[15:8] = sbyte;
        end
        default: rdata_d = '0; // Unmapped reads as zero
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ctrl_q <= isr_pkg::CTRL_RESET;
      busaddr_q <= isr_pkg::BUSADDR_RESET;
      ppcfg_q <= isr_pkg::PPCFG_RESET;
      aerr_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      busaddr_q <= busaddr_d;
      ppcfg_q <= ppcfg_d;
      aerr_q <= aerr_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Service request sources
  // ----------------------------------------------------------------
  logic [isr_pkg::NUM_OUT-1:0] fault_prev_q; // Fault levels last cycle
  logic [isr_pkg::NUM_OUT-1:0] flt_q, flt_d; // Latched fault causes
  logic perr_q, perr_d; // Latched programming error
  logic pon_q, pon_d; // Latched power-on cause
  logic pon_arm_q; // One-shot after reset release
  logic clr_req; // Clear command or Device Clear

  assign clr_req = clear_supply_command_i | dcl_rise;

  // Cause latches; set wins over every clear
  always_comb
  begin
    flt_d = flt_q;
    perr_d = perr_q;
    pon_d = pon_q;
    if (spoll_end || clr_req)
    begin
      flt_d = '0;
      perr_d = 1'b0;
      pon_d = 1'b0;
    end
    flt_d = flt_d | (fault_i & ~fault_prev_q &
                     ctrl_q[isr_pkg::CTRL_FLT_LSB +: isr_pkg::NUM_OUT]);
    if (prog_err_i && ctrl_q[isr_pkg::CTRL_PERR_BIT])
    begin
      perr_d = 1'b1;
    end
    if (pon_arm_q && ctrl_q[isr_pkg::CTRL_PON_BIT])
    begin
      pon_d = 1'b1;
    end
  end

  // Cause storage; power-on armed once per reset
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      fault_prev_q <= '0;
      flt_q <= '0;
      perr_q <= 1'b0;
      pon_q <= 1'b0;
      pon_arm_q <= 1'b1;
    end
    else
    begin
      fault_prev_q <= fault_i;
      flt_q <= flt_d;
      perr_q <= perr_d;
      pon_q <= pon_d;
      pon_arm_q <= 1'b0;
    end
  end

  // Only causes drive the flag, no poll term
  assign rqs = (|flt_q) | perr_q | pon_q;

  // Status byte with request in bit 6
  always_comb
  begin
    sbyte = 8'h00;
    sbyte[isr_pkg::SB_FLT_LSB +: isr_pkg::NUM_OUT] = flt_q;
    sbyte[isr_pkg::SB_PERR_BIT] = perr_q;
    sbyte[isr_pkg::SB_PON_BIT] = pon_q;
    sbyte[isr_pkg::SB_RQS_BIT] = rqs;
  end

  assign srq_n_o = 1'b0;
  assign srq_n_oe_o = rqs;
  assign srq_led_o = rqs;
  assign addr_led_o = sync2_q.lstn | sync2_q.tlkr;

  // ----------------------------------------------------------------
  // Data lines: serial and parallel poll
  // ----------------------------------------------------------------
  logic [7:0] dio_d, dio_q; // Data line values
  logic [7:0] oe_d, oe_q; // Data line enables
  logic [2:0] pp_line; // Chosen response line

  // Talker with serial poll, parallel poll
  always_comb
  begin
    dio_d = 8'h00;
    oe_d = 8'h00;
    pp_line = 3'h0;
    // Status byte while polled as talker
    if (sync2_q.spas && sync2_q.tlkr && !sync2_q.atn)
    begin
      dio_d = sbyte;
      oe_d = 8'hFF;
    end
    else if (ppoll)
    begin
      if (ppcfg_q[isr_pkg::PP_CFG_BIT])
      begin
        pp_line = ppcfg_q[isr_pkg::PP_LINE_LSB +: 3];
        if (rqs == ppcfg_q[isr_pkg::PP_SENSE_BIT])
        begin
          dio_d[pp_line] = 1'b1;
          oe_d[pp_line] = 1'b1;
        end
      end
      else if (busaddr_q <= isr_pkg::PP_DEFAULT_MAX && rqs)
      begin
        pp_line = busaddr_q[2:0];
        dio_d[pp_line] = 1'b1;
        oe_d[pp_line] = 1'b1;
      end
    end
  end

  // Data lines registered
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      dio_q <= 8'h00;
      oe_q <= 8'h00;
    end
    else
    begin
      dio_q <= dio_d;
      oe_q <= oe_d;
    end
  end

  assign dio_o = dio_q;
  assign dio_oe_o = oe_q;

  // ----------------------------------------------------------------
  // Remote/local state
  // ----------------------------------------------------------------
  // Settings live elsewhere and are never touched here, so a state
  // change cannot alter programmed outputs.
  always_comb
  begin
    rl_d = rl_q;
    if (!sync2_q.ren)
    begin
      rl_d = isr_pkg::ISR_LOCAL; // Dropping REN frees everything
    end
    else
    begin
      unique case (rl_q)
        isr_pkg::ISR_LOCAL:
        begin
          if (sync2_q.lstn)
          begin
            rl_d = sync2_q.llo ? isr_pkg::ISR_REMOTE_LOCK
                               : isr_pkg::ISR_REMOTE;
          end
          // Lockout message from the bus only
          else if (sync2_q.llo)
          begin
            rl_d = isr_pkg::ISR_LOCAL_LOCK;
          end
        end
        isr_pkg::ISR_REMOTE:
        begin
          if (sync2_q.llo)
          begin
            rl_d = isr_pkg::ISR_REMOTE_LOCK;
          end
          else if (gtl_rise)
          begin
            rl_d = isr_pkg::ISR_LOCAL;
          end
          else if (return_to_local_key_i && !cmd_busy_i)
          begin
            rl_d = isr_pkg::ISR_LOCAL;
          end
        end
        isr_pkg::ISR_REMOTE_LOCK:
        begin
          if (gtl_rise)
          begin
            rl_d = isr_pkg::ISR_LOCAL_LOCK;
          end
        end
        isr_pkg::ISR_LOCAL_LOCK:
        begin
          if (sync2_q.lstn)
          begin
            rl_d = isr_pkg::ISR_REMOTE_LOCK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rl_q <= isr_pkg::ISR_LOCAL;
    end
    else
    begin
      rl_q <= rl_d;
    end
  end

  // Front panel programming allowed only in plain local
  assign panel_prog_en_o = (rl_q == isr_pkg::ISR_LOCAL);
  assign remote_led_o = (rl_q == isr_pkg::ISR_REMOTE) |
                        (rl_q == isr_pkg::ISR_REMOTE_LOCK);

endmodule : isr_core

//--- logic/isr_pkg.sv
/*
  Constants, register map, state and carrier types for the instrument bus
  service request and poll block.
  Assumes one 100 MHz clock and a synchronous active-high reset.
*/
package isr_pkg;

  // ----------------------------------------------------------------
  // Register port geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register offsets (byte addresses)
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_BUSADDR = 4'h4;
  localparam logic [3:0] OFS_PPCFG = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // CTRL fields
  localparam int CTRL_PON_BIT = 0;
  localparam int CTRL_FLT_LSB = 1;
  localparam int CTRL_PERR_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h3F;

  // Bus address field and range
  localparam int BUSADDR_W = 5;
  localparam logic [4:0] BUSADDR_MAX = 5'h1E;
  localparam logic [4:0] BUSADDR_RESET = 5'h05;
  localparam logic [4:0] PP_DEFAULT_MAX = 5'h07;

  // PPCFG fields
  localparam int PP_LINE_LSB = 0;
  localparam int PP_SENSE_BIT = 3;
  localparam int PP_CFG_BIT = 7;
  localparam logic [7:0] PPCFG_RESET = 8'h00;

  // STATUS fields
  localparam int ST_RQS_BIT = 0;
  localparam int ST_REM_BIT = 1;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_AERR_BIT = 3;
  localparam int ST_SRQLINE_BIT = 4;
  localparam int ST_BYTE_LSB = 8;

  // Serial poll status byte fields
  localparam int NUM_OUT = 4;
  localparam int SB_FLT_LSB = 0;
  localparam int SB_PERR_BIT = 4;
  localparam int SB_PON_BIT = 5;
  localparam int SB_RQS_BIT = 6;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ISR_LOCAL,
    ISR_REMOTE,
    ISR_REMOTE_LOCK,
    ISR_LOCAL_LOCK
  } isr_rl_t;

  // Bus-side pin levels, raw and after synchronising
  typedef struct packed {
    logic ren;
    logic atn;
    logic eoi;
    logic lstn;
    logic tlkr;
    logic spas;
    logic dcl;
    logic gtl;
    logic llo;
    logic srq_n;
  } isr_pins_t;

endpackage : isr_pkg

//--- testbench/isr_core_props.sv
/*
  Checker for the service request and poll block.
  Assumes it is bound to isr_core and sees only its ports.
*/
`timescale 1ns/10ps
module isr_core_props
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ren_i,
  input wire logic atn_i,
  input wire logic eoi_i,
  input wire logic listen_addr_i,
  input wire logic talk_addr_i,
  input wire logic spoll_active_i,
  input wire logic dev_clear_i,
  input wire logic [isr_pkg::NUM_OUT-1:0] fault_i,
  input wire logic prog_err_i,
  input wire logic clear_supply_command_i,
  input wire logic cmd_busy_i,
  input wire logic return_to_local_key_i,
  input wire logic srq_n_o,
  input wire logic srq_n_oe_o,
  input wire logic [7:0] dio_oe_o,
  input wire logic srq_led_o,
  input wire logic addr_led_o,
  input wire logic remote_led_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);

  // ------------------------------------------------------------
  // Cycles since a poll or bus clear was seen
  // ------------------------------------------------------------
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;

  // Saturates so a long idle time never wraps back to small
  always_comb
  begin
    if (spoll_active_i || dev_clear_i)
      quiet_d = 4'h0;
    else if (quiet_q != 4'hF)
      quiet_d = quiet_q + 4'h1;
    else
      quiet_d = quiet_q;
  end

  // Register only
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      quiet_q <= 4'h0;
    else
      quiet_q <= quiet_d;
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_srq_led;
    (srq_led_o == srq_n_oe_o) && !srq_n_o;
  endproperty
  a_srq_led: assert property (p_srq_led)
    else $error("SRQ drive and indicator disagree");

  property p_fault;
    (fault_i & ~$past(fault_i)) != 4'h0 |=> srq_n_oe_o;
  endproperty
  a_fault: assert property (p_fault)
    else $error("Fault edge raised no request");

  property p_perr;
    prog_err_i |=> srq_n_oe_o && srq_led_o;
  endproperty
  a_perr: assert property (p_perr)
    else $error("Programming error raised no request");

  property p_clr;
    clear_supply_command_i && !prog_err_i && $stable(fault_i)
      |=> !srq_n_oe_o;
  endproperty
  a_clr: assert property (p_clr)
    else $error("Clear command left request pending");

  property p_spoll_clr;
    $fell(spoll_active_i) |-> ##[1:6] !srq_n_oe_o;
  endproperty
  a_spoll_clr: assert property (p_spoll_clr)
    else $error("Serial poll left request pending");

  property p_no_spur_clr;
    $fell(srq_n_oe_o) |-> $past(clear_supply_command_i) || quiet_q < 4'h8;
  endproperty
  a_no_spur_clr: assert property (p_no_spur_clr)
    else $error("Request dropped without a clearing cause");

  property p_spoll_byte;
    (spoll_active_i && talk_addr_i && !atn_i) [*4] |-> dio_oe_o == 8'hFF;
  endproperty
  a_spoll_byte: assert property (p_spoll_byte)
    else $error("Serial poll byte not driven");

  property p_key_busy;
    return_to_local_key_i && cmd_busy_i && remote_led_o && ren_i
      |=> remote_led_o;
  endproperty
  a_key_busy: assert property (p_key_busy)
    else $error("Busy remote state left by key");

  property p_addr;
    (listen_addr_i || talk_addr_i) [*4] |-> addr_led_o;
  endproperty
  a_addr: assert property (p_addr)
    else $error("Addressed indicator dark");

  c_spoll: cover property ($fell(spoll_active_i) && srq_n_oe_o);
  c_ppoll: cover property (atn_i && eoi_i && srq_n_oe_o);
  c_remote: cover property ($rose(remote_led_o));
endmodule : isr_core_props

//--- testbench/isr_ctl_model.sv
/*
  Bus controller model: drives the bus control levels and resolves the
  pulled-up SRQ line and the data lines, which read low when released.
  Assumes drive() is called from one bench process only.
*/
`timescale 1ns/10ps
module isr_ctl_model
(
  input wire logic clock_i,
  input wire logic dut_srq_n_i,
  input wire logic dut_srq_oe_i,
  input wire logic [7:0] dut_dio_i,
  input wire logic [7:0] dut_dio_oe_i,
  output logic [8:0] ctl_o,
  output logic srq_n_line_o
);
  logic [7:0] dio_bus; // Resolved data lines

  // Released lines fall back to the not-asserted level
  assign srq_n_line_o = dut_srq_oe_i ? dut_srq_n_i : 1'b1;
  assign dio_bus = dut_dio_oe_i & dut_dio_i;

  initial
  begin
    ctl_o = 9'h000;
  end

  task automatic drive(input logic [8:0] v, output logic [15:0] r);
    @(posedge clock_i);
    ctl_o <= v;
    repeat (5) @(posedge clock_i);
    #1 r = {dut_dio_oe_i, dio_bus};
  endtask : drive
endmodule : isr_ctl_model

//--- testbench/test_isr_core.sv
/*
  Self-checking bench for the service request and poll block.
  Assumes a 100 MHz clock and the controller model beside the design.
*/
`timescale 1ns/10ps
module test_isr_core;
  // Bus levels {ren,atn,eoi,listen,talk,spoll,dcl,gtl,llo}
  localparam logic [8:0] IDLE = 9'h000;
  localparam logic [8:0] SP = 9'h018;
  localparam logic [8:0] PP = 9'h0C0;
  localparam logic [8:0] DC = 9'h004;
  localparam logic [8:0] REM = 9'h120;
  localparam logic [8:0] RENO = 9'h100;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic [3:0] fault_i = 4'h0;
  logic prog_err_i = 1'b0;
  logic clr_i = 1'b0;
  logic busy_i = 1'b0;
  logic key_i = 1'b0;
  logic srq_n_o, srq_n_oe_o, srq_n_line, panel_o, srq_led_o;
  logic addr_led_o, remote_o;
  logic [7:0] dio_o, dio_oe_o;
  logic [8:0] ctl;
  logic [15:0] r;
  logic [4:0] a;
  int error_cnt = 0;
  int cmp_count = 0;

  initial
  begin
    forever #5 clock_i = ~clock_i;
  end

  isr_core isr_core_i (.clock_i(clock_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ren_i(ctl[8]), .atn_i(ctl[7]), .eoi_i(ctl[6]),
    .listen_addr_i(ctl[5]), .talk_addr_i(ctl[4]),
    .spoll_active_i(ctl[3]), .dev_clear_i(ctl[2]),
    .go_to_local_i(ctl[1]), .lockout_i(ctl[0]), .srq_n_i(srq_n_line),
    .srq_n_o(srq_n_o), .srq_n_oe_o(srq_n_oe_o), .dio_o(dio_o),
    .dio_oe_o(dio_oe_o), .fault_i(fault_i), .prog_err_i(prog_err_i),
    .clear_supply_command_i(clr_i), .cmd_busy_i(busy_i),
    .return_to_local_key_i(key_i), .panel_prog_en_o(panel_o),
    .srq_led_o(srq_led_o), .addr_led_o(addr_led_o),
    .remote_led_o(remote_o));

  isr_ctl_model isr_ctl_model_i (.clock_i(clock_i),
    .dut_srq_n_i(srq_n_o), .dut_srq_oe_i(srq_n_oe_o),
    .dut_dio_i(dio_o), .dut_dio_oe_i(dio_oe_o), .ctl_o(ctl),
    .srq_n_line_o(srq_n_line));

  // Compare and count
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge clock_i);
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] ad, output logic [15:0] d);
    @(posedge clock_i);
    reg_addr_i <= ad;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd

  // One-cycle pulse: 0 prog error, 1 clear, 2 key
  task automatic pulse(input int k);
    @(posedge clock_i);
    prog_err_i <= (k == 0);
    clr_i <= (k == 1);
    key_i <= (k == 2);
    @(posedge clock_i);
    {prog_err_i, clr_i, key_i} <= 3'h0;
    #1;
  endtask : pulse

  task automatic test_done;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    test_done;
  end

  initial
  begin
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1 chk("pon", 16'h1, srq_n_oe_o);
    rd(isr_pkg::OFS_CTRL, r); chk("ctrl", 16'h003F, r);
    rd(isr_pkg::OFS_BUSADDR, r); chk("addr", 16'h0005, r);
    rd(isr_pkg::OFS_PPCFG, r); chk("ppcfg", 16'h0000, r);
    rd(4'h2, r); chk("unmapped", 16'h0000, r);
    isr_ctl_model_i.drive(SP, r);
    chk("sp_oe", 16'h00FF, r[15:8]);
    chk("rqs", 16'h1, r[6]);
    isr_ctl_model_i.drive(IDLE, r);
    chk("sp_clr", 16'h0, {srq_n_oe_o, srq_led_o});
    @(posedge clock_i);
    fault_i <= 4'h4;
    @(posedge clock_i);
    #1 chk("flt", 16'h1, srq_n_oe_o);
    // Default response line follows the bus address
    for (int i = 0; i < 5; i++)
    begin
      a = (i == 0) ? 5'd5 : (i == 1) ? 5'd0 : (i == 2) ? 5'd7 :
          (i == 3) ? 5'd8 : 5'd30;
      wr(isr_pkg::OFS_BUSADDR, {11'h000, a});
      isr_ctl_model_i.drive(PP, r);
      chk("pp", (a < 5'd8) ? 16'h0101 << a : 16'h0, r);
      isr_ctl_model_i.drive(IDLE, r);
    end
    chk("pp_keep", 16'h1, srq_n_oe_o);
    wr(isr_pkg::OFS_PPCFG, 16'h008B);
    isr_ctl_model_i.drive(PP, r);
    chk("pp_s1", 16'h1, r[11] & r[3]);
    wr(isr_pkg::OFS_PPCFG, 16'h0083);
    isr_ctl_model_i.drive(PP, r);
    chk("pp_s0", 16'h0, r[3]);
    isr_ctl_model_i.drive(IDLE, r);
    wr(isr_pkg::OFS_PPCFG, 16'h0000);
    isr_ctl_model_i.drive(SP, r);
    chk("sp_flt", 16'h1, r[2]);
    isr_ctl_model_i.drive(IDLE, r);
    chk("sp_cond", 16'h0, srq_n_oe_o);
    pulse(0); chk("perr", 16'h1, srq_n_oe_o);
    pulse(1); chk("clr", 16'h0, srq_n_oe_o);
    @(posedge clock_i);
    fault_i <= 4'h5;
    isr_ctl_model_i.drive(DC, r);
    isr_ctl_model_i.drive(IDLE, r);
    chk("dcl", 16'h0, srq_n_oe_o);
    wr(isr_pkg::OFS_BUSADDR, 16'h001F);
    rd(isr_pkg::OFS_BUSADDR, r); chk("range", 16'h001E, r);
    rd(isr_pkg::OFS_STATUS, r); chk("aerr", 16'h1, r[3]);
    chk("st_low", 16'h0008, r[4:0]);
    rd(isr_pkg::OFS_STATUS, r); chk("aerr_rc", 16'h0, r[3]);
    wr(4'h2, 16'h0000);
    rd(isr_pkg::OFS_CTRL, r); chk("ctrl_keep", 16'h003F, r);
    isr_ctl_model_i.drive(REM, r);
    chk("rem", 16'h5, {remote_o, panel_o, addr_led_o});
    isr_ctl_model_i.drive(RENO, r);
    busy_i <= 1'b1;
    pulse(2); chk("busy", 16'h1, remote_o);
    busy_i <= 1'b0;
    pulse(2); chk("lcl", 16'h1, panel_o);
    isr_ctl_model_i.drive(REM, r);
    isr_ctl_model_i.drive(RENO | 9'h001, r);
    pulse(2); chk("lock", 16'h1, remote_o);
    isr_ctl_model_i.drive(RENO | 9'h003, r);
    chk("llock", 16'h0, {remote_o, panel_o});
    isr_ctl_model_i.drive(IDLE, r);
    chk("local", 16'h2, {panel_o, addr_led_o});
    rd(isr_pkg::OFS_BUSADDR, r); chk("keep", 16'h001E, r);
    test_done;
  end
endmodule : test_isr_core

bind isr_core isr_core_props isr_core_props_i (.clock_i(clock_i),
  .srst_i(srst_i), .ren_i(ren_i), .atn_i(atn_i), .eoi_i(eoi_i),
  .listen_addr_i(listen_addr_i), .talk_addr_i(talk_addr_i),
  .spoll_active_i(spoll_active_i), .dev_clear_i(dev_clear_i),
  .fault_i(fault_i), .prog_err_i(prog_err_i),
  .clear_supply_command_i(clear_supply_command_i),
  .cmd_busy_i(cmd_busy_i), .return_to_local_key_i(return_to_local_key_i),
  .srq_n_o(srq_n_o), .srq_n_oe_o(srq_n_oe_o), .dio_oe_o(dio_oe_o),
  .srq_led_o(srq_led_o), .addr_led_o(addr_led_o),
  .remote_led_o(remote_led_o));
